// ---- pkg/trainer_params.svh ----
// Address map, field widths and timing counts of the trainer decoder.
`ifndef TRAINER_PARAMS_SVH
`define TRAINER_PARAMS_SVH

// Width of the full byte address seen by the decoder.
`define ADDR_W 24

// Start-up words: stack pointer then start address.
`define RESET_VEC_LO 24'h000000
`define RESET_VEC_HI 24'h000007
// Exception and interrupt vector table.
`define VECTOR_LO 24'h000008
`define VECTOR_HI 24'h0003ff
// Monitor stack area.
`define STACK_LO 24'h000f80
`define STACK_HI 24'h000fff
// User program and data memory.
`define USER_RAM_LO 24'h001000
`define USER_RAM_HI 24'h003fff
// Erasable store window; only part of it is populated.
`define ERASE_LO 24'hfd8000
`define ERASE_HI 24'hfdffff
// Secondary monitor firmware socket pair.
`define SEC_FW_LO 24'hff0000
`define SEC_FW_HI 24'hff7fff

// Parallel port adapters share eight bytes: even keyboard, odd display.
`define PPA_LO 24'hfd0000
`define PPA_HI 24'hfd0007
// Serial port adapters: status/control at +1, data at +3.
`define SPA1_LO 24'hfd0040
`define SPA1_HI 24'hfd0043
`define SPA2_LO 24'hfd0060
`define SPA2_HI 24'hfd0063

// Least acknowledge delay in clock cycles, before the jumper adds to it.
`define ACK_DELAY_MIN 4'h1
// Width of the acknowledge delay jumper field.
`define ACK_SEL_W 3

// Bus fault timeout with no acknowledge, and the clock it is counted on.
`define FAULT_TIME_NS 2560
`define CLK_PERIOD_NS 10
`define FAULT_CYCLES (`FAULT_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- pkg/trainer_pkg.sv ----
// Types shared by the trainer address decoder and its helpers.
package trainer_pkg;

  // One-hot decode result for the current bus cycle.
  typedef enum logic [10:0] {
    REG_NONE      = 11'h001,
    REG_RESET_VEC = 11'h002,
    REG_VECTOR    = 11'h004,
    REG_STACK     = 11'h008,
    REG_USER_RAM  = 11'h010,
    REG_ERASABLE  = 11'h020,
    REG_SEC_FW    = 11'h040,
    REG_KBD_PPA   = 11'h080,
    REG_DISP_PPA  = 11'h100,
    REG_SPA1      = 11'h200,
    REG_SPA2      = 11'h400
  } region_t;

  // Memory socket-pair selects, active high.
  typedef struct packed {
    logic reset_vec;
    logic vector_mem;
    logic stack_mem;
    logic user_ram;
    logic erasable;
    logic sec_fw;
  } mem_sel_t;

  // Byte-lane strobes to the memory pairs, already gated with direction.
  typedef struct packed {
    logic upper_rd;
    logic upper_wr;
    logic lower_rd;
    logic lower_wr;
  } lane_t;

  // Peripheral adapter selects, active high.
  typedef struct packed {
    logic kbd_ppa;
    logic disp_ppa;
    logic spa1;
    logic spa2;
  } periph_sel_t;

endpackage

// ---- logic/pin_sync.sv ----
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] stable_r;
  logic [W-1:0] stable_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    meta_nxt = pin_in;
    stable_nxt = meta_r;
  end

  // Both stages reset to the idle level of the pins.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= INIT;
      stable_r <= INIT;
    end
    else
    begin
      meta_r <= meta_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign pin_sync_out = stable_r;

endmodule

// ---- logic/cycle_timer.sv ----
// Counter that flags when a condition has held for a given number of cycles.
`timescale 1ns/1ps
module cycle_timer
#(
  parameter int W = 8
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic expired_r;
  logic expired_nxt;

  // Count while run holds, park at the limit, restart when run drops.
  always_comb
  begin
    count_nxt = count_r;
    if (!run)
    begin
      count_nxt = '0;
    end
    else if (count_r != limit)
    begin
      count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
    end
    expired_nxt = run && (count_r == limit);
  end

  // Counter and flag registers.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r <= '0;
      expired_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;

endmodule

// ---- logic/trainer_address_decoder.sv ----
// Address decoder, byte-lane gating and cycle termination of the trainer.
`timescale 1ns/1ps
`include "trainer_params.svh"

// Overview of operation
// - Even FD0000-6 select keyboard parallel adapter registers.
// - Odd FD0001-7 select display parallel adapter registers.
// - FD0041 status, FD0043 data, first serial adapter.
// - FD0061 status, FD0063 data, second serial adapter.
// - FD8000-FDFFFF selects the partly populated erasable store.
// - FF0000-FF7FFF selects secondary firmware socket pair.
// - 000000-000007 give stack pointer and start address.
// - 000008-0003FF decode to the vector table memory.
// - 001000-003FFF decode to user read/write memory.
// - Paired 8-bit sockets form upper and lower lanes.
// - Byte strobes gated with direction; byte writes isolated.
// - Adapters finish via peripheral handshake, never acknowledge.
// - Acknowledge delay is configurable for the slowest device.
// - Missing acknowledge latches bus fault when jumper fitted.
// - Upper strobe means even byte, lower strobe odd.
module trainer_address_decoder
  import trainer_pkg::*;
#(
  parameter int ACK_W = 4,
  parameter int FAULT_W = 12,
  parameter int FAULT_CYCLES = `FAULT_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [23:1] addr_hi,
  input wire logic addr_valid_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic read_not_write,
  input wire logic valid_peripheral_address_n,
  input wire logic enable_clock,
  input wire logic bus_fault_jumper,
  input wire logic [`ACK_SEL_W-1:0] ack_delay_jumper,
  output mem_sel_t mem_sel,
  output lane_t mem_lane,
  output periph_sel_t periph_sel,
  output logic [1:0] periph_reg_idx,
  output logic periph_enable,
  output logic peripheral_cycle_req_n,
  output logic transfer_acknowledge_n,
  output logic bus_fault_n
);

  localparam int PIN_W = 23 + 7 + `ACK_SEL_W;
  // Idle pin levels: strobes, active-low inputs and read high, rest low, so that
  // no false address-strobed cycle is decoded while the synchroniser refills.
  localparam logic [PIN_W-1:0] PIN_IDLE = {23'h000000, 7'h7c, {`ACK_SEL_W{1'b0}}};
  localparam logic [FAULT_W-1:0] FAULT_LIMIT = FAULT_W'(FAULT_CYCLES);

  // Synchronised copies of the pins.
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic [23:1] addr_s;
  logic as_n_s;
  logic uds_n_s;
  logic lds_n_s;
  logic rw_s;
  logic vma_n_s;
  logic e_s;
  logic jumper_s;
  logic [`ACK_SEL_W-1:0] ack_sel_s;

  // Decode results for the current cycle.
  region_t region;
  logic cycle_act;
  logic upper_act;
  logic lower_act;

  // Select and strobe registers.
  mem_sel_t mem_sel_r;
  mem_sel_t mem_sel_nxt;
  lane_t lane_r;
  lane_t lane_nxt;
  periph_sel_t periph_sel_r;
  periph_sel_t periph_sel_nxt;
  logic [1:0] reg_idx_r;
  logic [1:0] reg_idx_nxt;
  logic periph_en_r;
  logic periph_en_nxt;
  logic vpa_n_r;
  logic vpa_n_nxt;

  // Cycle termination registers.
  logic ack_n_r;
  logic ack_n_nxt;
  logic fault_n_r;
  logic fault_n_nxt;
  logic mem_any_r;
  logic periph_any_r;
  logic ack_run;
  logic ack_done;
  logic fault_run;
  logic fault_done;
  logic [ACK_W-1:0] ack_limit;

  // Returns true when a byte address lies inside an inclusive window.
  function automatic logic in_win(
    input logic [`ADDR_W-1:0] a,
    input logic [`ADDR_W-1:0] lo,
    input logic [`ADDR_W-1:0] hi
  );
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // Maps the word address and the two byte strobes to one region.
  function automatic region_t decode_region(
    input logic [23:1] a,
    input logic upper,
    input logic lower
  );
    logic [`ADDR_W-1:0] ev;
    logic [`ADDR_W-1:0] od;
    ev = {a, 1'b0};
    od = {a, 1'b1};
    decode_region = REG_NONE;
    // The even byte rides the upper strobe, the odd byte the lower.
    if (in_win(ev, `RESET_VEC_LO, `RESET_VEC_HI))
    begin
      decode_region = REG_RESET_VEC;
    end
    else if (in_win(ev, `VECTOR_LO, `VECTOR_HI))
    begin
      decode_region = REG_VECTOR;
    end
    else if (in_win(ev, `STACK_LO, `STACK_HI))
    begin
      decode_region = REG_STACK;
    end
    else if (in_win(ev, `USER_RAM_LO, `USER_RAM_HI))
    begin
      decode_region = REG_USER_RAM;
    end
    else if (in_win(ev, `ERASE_LO, `ERASE_HI))
    begin
      decode_region = REG_ERASABLE;
    end
    else if (in_win(ev, `SEC_FW_LO, `SEC_FW_HI))
    begin
      decode_region = REG_SEC_FW;
    end
    else if (in_win(ev, `PPA_LO, `PPA_HI) && upper && !lower)
    begin
      decode_region = REG_KBD_PPA;
    end
    else if (in_win(od, `PPA_LO, `PPA_HI) && lower && !upper)
    begin
      decode_region = REG_DISP_PPA;
    end
    else if (in_win(od, `SPA1_LO, `SPA1_HI) && lower && !upper)
    begin
      decode_region = REG_SPA1;
    end
    else if (in_win(od, `SPA2_LO, `SPA2_HI) && lower && !upper)
    begin
      decode_region = REG_SPA2;
    end
  endfunction

  // Every pin is brought onto the clock through two flip-flops.
  assign pin_raw = {addr_hi, addr_valid_strobe_n, upper_byte_strobe_n,
                    lower_byte_strobe_n, valid_peripheral_address_n,
                    read_not_write, enable_clock, bus_fault_jumper,
                    ack_delay_jumper};

  pin_sync #(
    .W(PIN_W),
    .INIT(PIN_IDLE)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(pin_raw),
    .pin_sync_out(pin_s)
  );

  // Unpack the synchronised pins.
  assign addr_s = pin_s[PIN_W-1 -: 23];
  assign as_n_s = pin_s[`ACK_SEL_W + 6];
  assign uds_n_s = pin_s[`ACK_SEL_W + 5];
  assign lds_n_s = pin_s[`ACK_SEL_W + 4];
  assign vma_n_s = pin_s[`ACK_SEL_W + 3];
  assign rw_s = pin_s[`ACK_SEL_W + 2];
  assign e_s = pin_s[`ACK_SEL_W + 1];
  assign jumper_s = pin_s[`ACK_SEL_W];
  assign ack_sel_s = pin_s[`ACK_SEL_W-1:0];

  // Decoding happens only inside an address-strobed cycle, one region at most.
  assign cycle_act = !as_n_s;
  assign upper_act = !uds_n_s;
  assign lower_act = !lds_n_s;
  assign region = cycle_act ? decode_region(addr_s, upper_act, lower_act)
                            : REG_NONE;

  // Memory selects and byte-lane strobes.
  always_comb
  begin
    mem_sel_nxt.reset_vec = (region == REG_RESET_VEC);
    mem_sel_nxt.vector_mem = (region == REG_VECTOR);
    mem_sel_nxt.stack_mem = (region == REG_STACK);
    mem_sel_nxt.user_ram = (region == REG_USER_RAM);
    mem_sel_nxt.erasable = (region == REG_ERASABLE);
    mem_sel_nxt.sec_fw = (region == REG_SEC_FW);
    // Each pair drives both lanes; each lane has its own strobe.
    // Writes reach only the lane whose strobe is active.
    lane_nxt.upper_rd = (|mem_sel_nxt) && upper_act && rw_s;
    lane_nxt.lower_rd = (|mem_sel_nxt) && lower_act && rw_s;
    // Start-up words and firmware sit in read-only sockets.
    lane_nxt.upper_wr = (|mem_sel_nxt) && !mem_sel_nxt.reset_vec
                        && !mem_sel_nxt.sec_fw && upper_act && !rw_s;
    lane_nxt.lower_wr = (|mem_sel_nxt) && !mem_sel_nxt.reset_vec
                        && !mem_sel_nxt.sec_fw && lower_act && !rw_s;
  end

  // Memory select and lane registers.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_sel_r <= '0;
      lane_r <= '0;
    end
    else
    begin
      mem_sel_r <= mem_sel_nxt;
      lane_r <= lane_nxt;
    end
  end

  // Peripheral selects, register index and the slow handshake.
  always_comb
  begin
    periph_sel_nxt.kbd_ppa = (region == REG_KBD_PPA);
    periph_sel_nxt.disp_ppa = (region == REG_DISP_PPA);
    periph_sel_nxt.spa1 = (region == REG_SPA1);
    periph_sel_nxt.spa2 = (region == REG_SPA2);
    reg_idx_nxt = 2'h0;
    if (periph_sel_nxt.kbd_ppa || periph_sel_nxt.disp_ppa)
    begin
      reg_idx_nxt = addr_s[2:1];
    end
    else if (periph_sel_nxt.spa1 || periph_sel_nxt.spa2)
    begin
      reg_idx_nxt = {1'b0, addr_s[1]};
    end
    // Ask the processor for a peripheral cycle instead of acknowledging.
    vpa_n_nxt = !(|periph_sel_nxt);
    // The adapter is enabled only once the processor marks the address
    // valid and the enable clock is high.
    periph_en_nxt = (|periph_sel_nxt) && !vma_n_s && e_s;
  end

  // Peripheral registers.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      periph_sel_r <= '0;
      reg_idx_r <= 2'h0;
      vpa_n_r <= 1'b1;
      periph_en_r <= 1'b0;
    end
    else
    begin
      periph_sel_r <= periph_sel_nxt;
      reg_idx_r <= reg_idx_nxt;
      vpa_n_r <= vpa_n_nxt;
      periph_en_r <= periph_en_nxt;
    end
  end

  // The acknowledge delay grows with the jumper setting.
  assign ack_limit = ACK_W'(`ACK_DELAY_MIN) + ACK_W'(ack_sel_s);
  assign mem_any_r = |mem_sel_r;
  assign periph_any_r = |periph_sel_r;
  // Only memory cycles start the acknowledge delay.
  assign ack_run = mem_any_r && cycle_act;

  cycle_timer #(
    .W(ACK_W)
  ) u_ack_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(ack_run),
    .limit(ack_limit),
    .expired(ack_done)
  );

  // A strobed cycle with neither acknowledge nor peripheral handshake
  // runs the fault timeout; unmapped addresses end up here.
  assign fault_run = cycle_act && ack_n_r && !periph_any_r;

  cycle_timer #(
    .W(FAULT_W)
  ) u_fault_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(fault_run),
    .limit(FAULT_LIMIT),
    .expired(fault_done)
  );

  // Acknowledge and bus fault latch.
  always_comb
  begin
    // Acknowledge holds until the address strobe is withdrawn.
    ack_n_nxt = !(cycle_act && (ack_done || !ack_n_r));
    // The latch sets on timeout with the jumper fitted; a set in the
    // cycle that would clear it wins.
    fault_n_nxt = fault_n_r;
    if (fault_done && jumper_s)
    begin
      fault_n_nxt = 1'b0;
    end
    else if (!cycle_act)
    begin
      fault_n_nxt = 1'b1;
    end
  end

  // Termination registers.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_n_r <= 1'b1;
      fault_n_r <= 1'b1;
    end
    else
    begin
      ack_n_r <= ack_n_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  // All outputs come straight from registers.
  assign mem_sel = mem_sel_r;
  assign mem_lane = lane_r;
  assign periph_sel = periph_sel_r;
  assign periph_reg_idx = reg_idx_r;
  assign periph_enable = periph_en_r;
  assign peripheral_cycle_req_n = vpa_n_r;
  assign transfer_acknowledge_n = ack_n_r;
  assign bus_fault_n = fault_n_r;

endmodule

// ---- tb/trainer_address_decoder_checker.sv ----
// Concurrent checks on the ports of the trainer address decoder.
`timescale 1ns/1ps
module decoder_checker
  import trainer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [23:1] addr_hi,
  input wire logic addr_valid_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic read_not_write,
  input wire mem_sel_t mem_sel,
  input wire lane_t mem_lane,
  input wire periph_sel_t periph_sel,
  input wire logic periph_enable,
  input wire logic peripheral_cycle_req_n,
  input wire logic transfer_acknowledge_n,
  input wire logic bus_fault_n
);
  logic [26:0] pins;
  logic [26:0] pins_r;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [9:0] exp_sel;
  logic [3:0] exp_lane;
  logic [23:0] a;
  logic ev;
  logic od;
  logic mem;
  logic ro;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  assign pins = {addr_hi, addr_valid_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
    read_not_write};
  // Counts how long the bus pins have held still, saturating at seven.
  always_comb
  begin
    cnt_nxt = (pins != pins_r) ? 3'h0 : cnt_r + ((cnt_r == 3'h7) ? 3'h0 : 3'h1);
  end
  // Registers the pin history.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 3'h0;
      pins_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pins_r <= pins;
    end
  end
  // Works out the selects and lanes that steady pins should give.
  always_comb
  begin
    a = {addr_hi, 1'b0};
    ev = !upper_byte_strobe_n && lower_byte_strobe_n;
    od = upper_byte_strobe_n && !lower_byte_strobe_n;
    exp_sel = '0;
    if (!addr_valid_strobe_n)
    begin
      exp_sel[9] = a <= 24'h000007;
      exp_sel[8] = a >= 24'h000008 && a <= 24'h0003ff;
      exp_sel[7] = a >= 24'h000f80 && a <= 24'h000fff;
      exp_sel[6] = a >= 24'h001000 && a <= 24'h003fff;
      exp_sel[5] = a >= 24'hfd8000 && a <= 24'hfdffff;
      exp_sel[4] = a >= 24'hff0000 && a <= 24'hff7fff;
      exp_sel[3] = (a & 24'hfffff8) == 24'hfd0000 && ev;
      exp_sel[2] = (a & 24'hfffff8) == 24'hfd0000 && od;
      exp_sel[1] = (a & 24'hfffffc) == 24'hfd0040 && od;
      exp_sel[0] = (a & 24'hfffffc) == 24'hfd0060 && od;
    end
    mem = |exp_sel[9:4];
    ro = exp_sel[9] || exp_sel[4];
    exp_lane = {mem && !upper_byte_strobe_n && read_not_write,
      mem && !upper_byte_strobe_n && !read_not_write && !ro,
      mem && !lower_byte_strobe_n && read_not_write,
      mem && !lower_byte_strobe_n && !read_not_write && !ro};
  end
  a_sel_onehot: assert property ($onehot0({mem_sel, periph_sel}))
    else $error("more than one select active");
  a_decode_map: assert property (pins == pins_r && cnt_r >= 3'h4 |->
    {mem_sel, periph_sel} == exp_sel)
    else $error("selects differ from address map");
  a_lane_gate: assert property (pins == pins_r && cnt_r >= 3'h4 |->
    mem_lane == exp_lane)
    else $error("byte lanes differ from strobes");
  a_periph_no_ack: assert property (|periph_sel |-> transfer_acknowledge_n)
    else $error("acknowledge during adapter cycle");
  a_periph_req: assert property (|periph_sel |-> !peripheral_cycle_req_n)
    else $error("adapter selected without cycle request");
  a_enable_sel: assert property (periph_enable |-> |periph_sel)
    else $error("adapter enable without select");
  a_ack_early: assert property ($rose(|mem_sel) |-> transfer_acknowledge_n [*3])
    else $error("acknowledge too early");
  a_ack_bound: assert property ($rose(|mem_sel) |->
    ##[3:10] (!transfer_acknowledge_n || !(|mem_sel)))
    else $error("acknowledge too late");
  a_ack_needs_sel: assert property (!transfer_acknowledge_n |-> |mem_sel)
    else $error("acknowledge without memory select");
  a_fault_cause: assert property ($fell(bus_fault_n) |->
    transfer_acknowledge_n && !(|{mem_sel, periph_sel}))
    else $error("bus fault on a decoded cycle");
endmodule

bind trainer_address_decoder decoder_checker chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .addr_hi(addr_hi), .addr_valid_strobe_n(addr_valid_strobe_n),
  .upper_byte_strobe_n(upper_byte_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
  .read_not_write(read_not_write), .mem_sel(mem_sel), .mem_lane(mem_lane),
  .periph_sel(periph_sel), .periph_enable(periph_enable),
  .peripheral_cycle_req_n(peripheral_cycle_req_n),
  .transfer_acknowledge_n(transfer_acknowledge_n), .bus_fault_n(bus_fault_n));

// ---- tb/bus_master_model.sv ----
// Behavioural bus master that runs cycles against the decoder.
`timescale 1ns/1ps
module bus_master_model
  import trainer_pkg::*;
(
  input wire logic clk_sys,
  output logic [23:1] addr_hi,
  output logic addr_valid_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic read_not_write,
  output logic valid_peripheral_address_n,
  output logic enable_clock,
  input wire mem_sel_t mem_sel,
  input wire lane_t mem_lane,
  input wire periph_sel_t periph_sel,
  input wire logic [1:0] periph_reg_idx,
  input wire logic periph_enable,
  input wire logic peripheral_cycle_req_n,
  input wire logic transfer_acknowledge_n,
  input wire logic bus_fault_n
);
  int res;
  int lat;
  mem_sel_t c_mem;
  lane_t c_lane;
  periph_sel_t c_per;
  logic [1:0] c_idx;
  logic [3:0] e_cnt = 4'h0;
  // Idle bus levels at time zero.
  initial
  begin
    addr_hi = '0;
    addr_valid_strobe_n = 1'b1;
    upper_byte_strobe_n = 1'b1;
    lower_byte_strobe_n = 1'b1;
    read_not_write = 1'b1;
    valid_peripheral_address_n = 1'b1;
    enable_clock = 1'b0;
  end
  // Free-running slow enable clock, high four of every ten cycles.
  always @(posedge clk_sys)
  begin
    e_cnt <= (e_cnt == 4'h9) ? 4'h0 : e_cnt + 4'h1;
    enable_clock <= (e_cnt < 4'h4);
  end
  // One bus cycle; the lowest address bit only shows through the strobes.
  task automatic cycle(input logic [23:0] a, input logic up, input logic lo, input logic rd);
    int n;
    int t_sel;
    n = 0;
    t_sel = -1;
    res = 0;
    lat = -1;
    @(posedge clk_sys);
    addr_hi <= a[23:1];
    read_not_write <= rd;
    addr_valid_strobe_n <= 1'b0;
    upper_byte_strobe_n <= !up;
    lower_byte_strobe_n <= !lo;
    while (res == 0 && n < 60)
    begin
      @(posedge clk_sys);
      n++;
      if (|mem_sel && t_sel < 0) t_sel = n;
      if (!peripheral_cycle_req_n) valid_peripheral_address_n <= 1'b0;
      c_mem = mem_sel;
      c_lane = mem_lane;
      c_per = periph_sel;
      c_idx = periph_reg_idx;
      if (!transfer_acknowledge_n) lat = n - t_sel;
      if (!transfer_acknowledge_n) res = 1;
      else if (periph_enable) res = 2;
      else if (!bus_fault_n) res = 3;
    end
    addr_valid_strobe_n <= 1'b1;
    upper_byte_strobe_n <= 1'b1;
    lower_byte_strobe_n <= 1'b1;
    valid_peripheral_address_n <= 1'b1;
    addr_hi <= ~a[23:1];
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ---- tb/trainer_address_decoder_tb.sv ----
// Self-checking testbench for the trainer address decoder.
`timescale 1ns/1ps
module trainer_address_decoder_tb;
  import trainer_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n;
  logic bus_fault_jumper;
  logic [2:0] ack_delay_jumper;
  logic [23:1] addr_hi;
  logic as_n, us_n, ls_n, rw, vpa_n, ena;
  mem_sel_t mem_sel;
  lane_t mem_lane;
  periph_sel_t periph_sel;
  logic [1:0] idx;
  logic pen, req_n, ack_n, bus_fault_n;
  int fail_count = 0;
  int tests_run = 0;
  localparam logic [23:0] SER [4] = '{24'hfd0041, 24'hfd0043, 24'hfd0061, 24'hfd0063};
  localparam logic [23:0] MA [12] = '{24'h000000, 24'h000006, 24'h000008, 24'h0003fe,
    24'h000f80, 24'h000ffe, 24'h001000, 24'h003ffe, 24'hfd8000, 24'hfdfffe,
    24'hff0000, 24'hff7ffe};
  // Clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;
  bus_master_model pm (.clk_sys(clk_sys), .addr_hi(addr_hi), .addr_valid_strobe_n(as_n),
    .upper_byte_strobe_n(us_n), .lower_byte_strobe_n(ls_n), .read_not_write(rw),
    .valid_peripheral_address_n(vpa_n), .enable_clock(ena), .mem_sel(mem_sel),
    .mem_lane(mem_lane), .periph_sel(periph_sel), .periph_reg_idx(idx),
    .periph_enable(pen), .peripheral_cycle_req_n(req_n),
    .transfer_acknowledge_n(ack_n), .bus_fault_n(bus_fault_n));
  // The fault timeout must outlast the longest acknowledge delay.
  trainer_address_decoder #(.FAULT_CYCLES(16)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .addr_hi(addr_hi), .addr_valid_strobe_n(as_n), .upper_byte_strobe_n(us_n),
    .lower_byte_strobe_n(ls_n), .read_not_write(rw), .valid_peripheral_address_n(vpa_n),
    .enable_clock(ena), .bus_fault_jumper(bus_fault_jumper),
    .ack_delay_jumper(ack_delay_jumper), .mem_sel(mem_sel), .mem_lane(mem_lane),
    .periph_sel(periph_sel), .periph_reg_idx(idx), .periph_enable(pen),
    .peripheral_cycle_req_n(req_n), .transfer_acknowledge_n(ack_n),
    .bus_fault_n(bus_fault_n));
  // Counts a comparison and reports a mismatch.
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // Every adapter register, each with its strobe and register index.
  task automatic t_periph();
    logic [23:0] a;
    periph_sel_t e;
    logic [1:0] ei;
    for (int i = 0; i < 12; i++)
    begin
      a = (i < 8) ? 24'hfd0000 + 24'(i) : SER[i - 8];
      e = (i < 8) ? {!a[0], a[0], 2'b00} : {2'b00, i < 10, i >= 10};
      ei = (i < 8) ? a[2:1] : {1'b0, a[1]};
      pm.cycle(a, !a[0], a[0], i < 6);
      check(pm.res == 2 && pm.c_mem === '0, "adapter cycle end");
      check(pm.c_per === e, "adapter select");
      check(pm.c_idx === ei, "adapter register index");
    end
  endtask
  // Region boundaries read as whole words.
  task automatic t_mem();
    for (int i = 0; i < 12; i++)
    begin
      pm.cycle(MA[i], 1'b1, 1'b1, 1'b1);
      check(pm.res == 1 && pm.lat == 3, "memory acknowledge");
      check(pm.c_mem === mem_sel_t'(6'h20 >> (i / 2)), "memory select");
      check(pm.c_lane === 4'b1010, "word read lanes");
    end
  endtask
  // Byte and word writes and an odd byte read in user memory.
  task automatic t_bytes();
    pm.cycle(24'h002000, 1'b1, 1'b0, 1'b0);
    check(pm.c_lane === 4'b0100, "upper byte write");
    pm.cycle(24'h002001, 1'b0, 1'b1, 1'b0);
    check(pm.c_lane === 4'b0001, "lower byte write");
    pm.cycle(24'h002002, 1'b1, 1'b1, 1'b0);
    check(pm.c_lane === 4'b0101, "word write");
    pm.cycle(24'h002003, 1'b0, 1'b1, 1'b1);
    check(pm.c_lane === 4'b0010, "lower byte read");
    pm.cycle(24'hff0000, 1'b1, 1'b1, 1'b0);
    check(pm.c_lane === 4'b0000, "firmware write blocked");
  endtask
  // Every acknowledge delay setting.
  task automatic t_ack();
    for (int j = 0; j < 8; j++)
    begin
      @(posedge clk_sys);
      ack_delay_jumper <= 3'(j);
      repeat (3) @(posedge clk_sys);
      pm.cycle(24'h001800, 1'b1, 1'b1, 1'b1);
      check(pm.res == 1 && pm.lat == 3 + j, "acknowledge delay");
    end
    ack_delay_jumper <= 3'h0;
  endtask
  // Unmapped and wrongly strobed cycles, with and without the fault jumper.
  task automatic t_fault();
    pm.cycle(24'h004000, 1'b1, 1'b1, 1'b1);
    check(pm.res == 3 && pm.c_mem === '0, "fault on unmapped");
    check(bus_fault_n === 1'b1, "fault cleared");
    pm.cycle(24'hfd0040, 1'b1, 1'b1, 1'b1);
    check(pm.res == 3 && pm.c_per === '0, "word strobe to adapter");
    pm.cycle(24'hfd0060, 1'b1, 1'b0, 1'b0);
    check(pm.res == 3 && pm.c_per === '0, "upper strobe to serial");
    @(posedge clk_sys);
    bus_fault_jumper <= 1'b0;
    repeat (3) @(posedge clk_sys);
    pm.cycle(24'h004000, 1'b1, 1'b1, 1'b1);
    check(pm.res == 0, "no fault without jumper");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hung run short.
  initial
  begin
    #100us;
    fail_count++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    arst_n = 1'b0;
    bus_fault_jumper = 1'b1;
    ack_delay_jumper = 3'h0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_periph();
    t_mem();
    t_bytes();
    t_ack();
    t_fault();
    close_out();
  end
endmodule
